// ---- include/vsc_pkg.sv ----
`default_nettype none
package vsc_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] VSC_OFF_HBEGIN = 8'h06;
  localparam logic [7:0] VSC_OFF_HEND = 8'h07;
  localparam logic [7:0] VSC_OFF_SYNC = 8'h08;
  localparam logic [7:0] VSC_OFF_STATUS = 8'h1F;

  localparam logic [7:0] VSC_RST_HBEGIN = 8'h00;
  localparam logic [7:0] VSC_RST_HEND = 8'h00;
  localparam logic [7:0] VSC_RST_SYNC = 8'h98;

  localparam int VSC_STAT_STD_BIT = 0;
  localparam int VSC_STAT_ODD_BIT = 1;
  localparam int VSC_STAT_ERR_BIT = 2;

  // ---------------------------------------------------------------------
  // Timing and range
  // ---------------------------------------------------------------------
  localparam int VSC_STEP_CLKS = 8;
  localparam logic [7:0] VSC_LIMIT_50HZ = 8'h6C;
  localparam logic [7:0] VSC_LIMIT_60HZ = 8'h6B;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    VSC_HTC_TV = 2'b00,
    VSC_HTC_VTR = 2'b01,
    VSC_HTC_RSVD = 2'b10,
    VSC_HTC_FAST = 2'b11
  } vsc_htc_t;

  typedef enum logic [1:0] {
    VSC_VN_NORMAL = 2'b00,
    VSC_VN_FAST = 2'b01,
    VSC_VN_FREE = 2'b10,
    VSC_VN_BYPASS = 2'b11
  } vsc_vnoise_t;

  typedef struct packed {
    logic auto_field_detect;
    logic forced_field_standard;
    logic forced_field_toggle;
    vsc_htc_t horiz_time_constant;
    logic horiz_loop_open;
    vsc_vnoise_t vert_noise_mode;
  } vsc_ctrl_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } vsc_regreq_t;

endpackage
`default_nettype wire

// ---- hdl/vsc_hsync_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsc_hsync_gen (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic line_ref_in,
  input wire logic signed [7:0] begin_in,
  input wire logic signed [7:0] end_in,
  input wire logic [7:0] center_in,
  output logic hsync_out
);
  import vsc_pkg::*;

  typedef struct packed {
    logic [2:0] sub;
    logic [8:0] step;
    logic hsync;
  } vsc_gen_state_t;

  vsc_gen_state_t st_ff;
  vsc_gen_state_t nxt_st;
  logic signed [9:0] pos;
  logic signed [9:0] b_w;
  logic signed [9:0] e_w;

  // ---------------------------------------------------------------------
  // Line position in steps of eight clocks, signed about the line centre
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    pos = $signed({1'b0, st_ff.step}) - $signed({2'b00, center_in});
    b_w = 10'(begin_in);
    e_w = 10'(end_in);
    if (line_ref_in) begin
      nxt_st.sub = 3'h0;
      nxt_st.step = 9'h000;
    end else begin
      nxt_st.sub = st_ff.sub + 3'h1;
      if (st_ff.sub == 3'(VSC_STEP_CLKS - 1) && st_ff.step != 9'h1FF) begin
        nxt_st.step = st_ff.step + 9'h001;
      end
    end
    if (b_w <= e_w) begin
      nxt_st.hsync = (pos >= b_w) && (pos < e_w);
    end else begin
      nxt_st.hsync = (pos >= b_w) || (pos < e_w);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hsync_out = st_ff.hsync;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  sequence s_step_edge;
    st_ff.sub == 3'h7 && !line_ref_in;
  endsequence

  AST_HSYNC_STEP_ALIGNED: assert property (@(posedge mclk_in) disable iff (srst_in)
    $rose(st_ff.hsync) |-> $past(st_ff.sub) == 3'h0 || $past(begin_in) != $past(begin_in, 2)
    || $past(end_in) != $past(end_in, 2) || $past(center_in) != $past(center_in, 2))
    else $error("Sync start not on an eight clock step.");
  AST_STEP_ADVANCE: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_step_edge ##0 (st_ff.step != 9'h1FF) |=> st_ff.step == $past(st_ff.step) + 9'h001)
    else $error("Step counter did not advance after eight clocks.");
endmodule // vsc_hsync_gen
`default_nettype wire

// ---- hdl/vsc_sync_ctrl.sv ----
//
// Function
// - The sync start position is an 8-bit signed delay counted in steps of eight clocks.
// - The sync stop position is a separate 8-bit signed delay in the same eight clock steps.
// - Automatic detection on lets the detector set the standard, off lets the forced bit.
// - With detection off, forced bit 0 is 50 Hz 625 lines and 1 is 60 Hz 525 lines.
// - The odd/even output toggles for interlaced sources, or every field when forced.
// - The time constant field selects TV, VTR, reserved or fast locking loop behaviour.
// - Loop bit 0 keeps the horizontal loop closed, 1 opens it with fixed frequency.
// - The vertical noise field selects normal, fast, free running or bypass.
`timescale 1ns/1ps
`default_nettype none
module vsc_sync_ctrl (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire vsc_pkg::vsc_regreq_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  input wire logic line_ref_in,
  input wire logic field_start_in,
  input wire logic detect_60hz_in,
  input wire logic source_interlaced_in,
  output logic hsync_out,
  output logic field_60hz_out,
  output logic odd_even_out,
  output vsc_pkg::vsc_htc_t horiz_time_constant_out,
  output logic horiz_loop_open_out,
  output vsc_pkg::vsc_vnoise_t vert_noise_mode_out,
  output logic delay_range_err_out
);
  import vsc_pkg::*;

  typedef struct packed {
    logic [7:0] hbegin;
    logic [7:0] hend;
    vsc_ctrl_t ctrl;
    logic field_60hz;
    logic odd_even;
    logic range_err;
    logic [7:0] rdata;
  } vsc_state_t;

  vsc_state_t st_ff;
  vsc_state_t nxt_st;
  logic std_now;
  logic signed [7:0] begin_lim;
  logic signed [7:0] end_lim;
  logic [7:0] limit;

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic vsc_in_range(input logic [7:0] v, input logic [7:0] lim);
    logic signed [8:0] sv;
    sv = 9'($signed(v));
    return (sv <= $signed({1'b0, lim})) && (sv >= -$signed({1'b0, lim}));
  endfunction

  function automatic logic [7:0] vsc_clamp(input logic [7:0] v, input logic [7:0] lim);
    logic [7:0] r;
    r = v;
    if (!vsc_in_range(v, lim)) begin
      r = v[7] ? 8'(-lim) : lim;
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // Control and field state
  // ---------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        VSC_OFF_HBEGIN: nxt_st.hbegin = reg_req_in.wdata;
        VSC_OFF_HEND: nxt_st.hend = reg_req_in.wdata;
        VSC_OFF_SYNC: nxt_st.ctrl = vsc_ctrl_t'(reg_req_in.wdata);
        default: nxt_st.ctrl = st_ff.ctrl;
      endcase
    end
    nxt_st.field_60hz = std_now;
    if (field_start_in && (source_interlaced_in || st_ff.ctrl.forced_field_toggle)) begin
      nxt_st.odd_even = !st_ff.odd_even;
    end
    nxt_st.range_err = !vsc_in_range(st_ff.hbegin, limit) || !vsc_in_range(st_ff.hend, limit);
    unique case (reg_req_in.addr)
      VSC_OFF_HBEGIN: nxt_st.rdata = st_ff.hbegin;
      VSC_OFF_HEND: nxt_st.rdata = st_ff.hend;
      VSC_OFF_SYNC: nxt_st.rdata = 8'(st_ff.ctrl);
      VSC_OFF_STATUS: begin
        nxt_st.rdata = 8'h00;
        nxt_st.rdata[VSC_STAT_STD_BIT] = st_ff.field_60hz;
        nxt_st.rdata[VSC_STAT_ODD_BIT] = st_ff.odd_even;
        nxt_st.rdata[VSC_STAT_ERR_BIT] = st_ff.range_err;
      end
      default: nxt_st.rdata = 8'h00;
    endcase
  end

  always_comb begin
    std_now = st_ff.ctrl.auto_field_detect ? detect_60hz_in
                                           : st_ff.ctrl.forced_field_standard;
    limit = st_ff.field_60hz ? VSC_LIMIT_60HZ : VSC_LIMIT_50HZ;
    begin_lim = $signed(vsc_clamp(st_ff.hbegin, limit));
    end_lim = $signed(vsc_clamp(st_ff.hend, limit));
  end

  always_ff @(posedge mclk_in) begin
    if (srst_in) begin
      st_ff.hbegin <= VSC_RST_HBEGIN;
      st_ff.hend <= VSC_RST_HEND;
      st_ff.ctrl <= vsc_ctrl_t'(VSC_RST_SYNC);
      st_ff.field_60hz <= 1'b0;
      st_ff.odd_even <= 1'b0;
      st_ff.range_err <= 1'b0;
      st_ff.rdata <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------
  // Sync pulse placement
  // ---------------------------------------------------------------------
  vsc_hsync_gen u_hsync_gen (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .line_ref_in(line_ref_in),
    .begin_in(begin_lim),
    .end_in(end_lim),
    .center_in(limit),
    .hsync_out(hsync_out)
  );

  // Reserved time constant code is passed on as stored; software must not use it.
  assign horiz_time_constant_out = st_ff.ctrl.horiz_time_constant;
  assign horiz_loop_open_out = st_ff.ctrl.horiz_loop_open;
  assign vert_noise_mode_out = st_ff.ctrl.vert_noise_mode;
  assign field_60hz_out = st_ff.field_60hz;
  assign odd_even_out = st_ff.odd_even;
  assign delay_range_err_out = st_ff.range_err;
  assign reg_rdata_out = st_ff.rdata;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  sequence s_wr_sync;
    reg_req_in.wr && reg_req_in.addr == VSC_OFF_SYNC;
  endsequence

  sequence s_wr_begin_max;
    reg_req_in.wr && reg_req_in.addr == VSC_OFF_HBEGIN && reg_req_in.wdata == 8'h7F;
  endsequence

  AST_STD_FORCED: assert property (@(posedge mclk_in) disable iff (srst_in)
    !st_ff.ctrl.auto_field_detect |=> field_60hz_out == $past(st_ff.ctrl.forced_field_standard))
    else $error("Forced field standard not followed.");
  AST_STD_AUTO: assert property (@(posedge mclk_in) disable iff (srst_in)
    st_ff.ctrl.auto_field_detect |=> field_60hz_out == $past(detect_60hz_in))
    else $error("Detected field standard not followed.");
  AST_TOGGLE: assert property (@(posedge mclk_in) disable iff (srst_in)
    field_start_in && (source_interlaced_in || st_ff.ctrl.forced_field_toggle)
    |=> odd_even_out != $past(odd_even_out))
    else $error("Odd/even output did not toggle.");
  AST_HOLD: assert property (@(posedge mclk_in) disable iff (srst_in)
    field_start_in && !source_interlaced_in && !st_ff.ctrl.forced_field_toggle
    |=> $stable(odd_even_out))
    else $error("Odd/even output toggled for non-interlaced source.");
  AST_FIELD_IDLE: assert property (@(posedge mclk_in) disable iff (srst_in)
    !field_start_in |=> $stable(odd_even_out))
    else $error("Odd/even output changed without a field start.");
  AST_HTC: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_wr_sync |=> horiz_time_constant_out == vsc_htc_t'($past(reg_req_in.wdata[4:3])))
    else $error("Time constant selection not taken.");
  AST_LOOP: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_wr_sync ##0 reg_req_in.wdata[2] |=> horiz_loop_open_out ##1 horiz_loop_open_out || $past(reg_req_in.wr))
    else $error("Horizontal loop not opened.");
  AST_LOOP_CLOSED: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_wr_sync ##0 !reg_req_in.wdata[2] |=> !horiz_loop_open_out)
    else $error("Horizontal loop not closed.");
  AST_VNOISE: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_wr_sync |=> vert_noise_mode_out == vsc_vnoise_t'($past(reg_req_in.wdata[1:0])))
    else $error("Vertical noise mode not taken.");
  AST_CTRL_HOLD: assert property (@(posedge mclk_in) disable iff (srst_in)
    !(reg_req_in.wr && reg_req_in.addr == VSC_OFF_SYNC) |=> $stable(horiz_time_constant_out)
    && $stable(horiz_loop_open_out) && $stable(vert_noise_mode_out))
    else $error("Loop or noise selection changed without a write.");
  AST_CLAMP: assert property (@(posedge mclk_in) disable iff (srst_in)
    field_60hz_out |-> begin_lim <= $signed(VSC_LIMIT_60HZ)
    && begin_lim >= -$signed(VSC_LIMIT_60HZ) && end_lim <= $signed(VSC_LIMIT_60HZ)
    && end_lim >= -$signed(VSC_LIMIT_60HZ))
    else $error("Delay outside 60 Hz range used.");
  AST_CLAMP_50: assert property (@(posedge mclk_in) disable iff (srst_in)
    !field_60hz_out |-> begin_lim <= $signed(VSC_LIMIT_50HZ)
    && begin_lim >= -$signed(VSC_LIMIT_50HZ) && end_lim <= $signed(VSC_LIMIT_50HZ)
    && end_lim >= -$signed(VSC_LIMIT_50HZ))
    else $error("Delay outside 50 Hz range used.");
  AST_ERR: assert property (@(posedge mclk_in) disable iff (srst_in)
    s_wr_begin_max ##1 !(reg_req_in.wr && reg_req_in.addr == VSC_OFF_HBEGIN)
    |=> delay_range_err_out)
    else $error("Out of range delay not flagged.");

  // ---------------------------------------------------------------------
  // Read-back checks
  // ---------------------------------------------------------------------
  // Read data always shows the register addressed one cycle earlier.
  AST_RD_START: assert property (@(posedge mclk_in) disable iff (srst_in)
    reg_req_in.addr == VSC_OFF_HBEGIN |=> reg_rdata_out == $past(st_ff.hbegin))
    else $error("Sync start read back wrong.");
  AST_RD_STOP: assert property (@(posedge mclk_in) disable iff (srst_in)
    reg_req_in.addr == VSC_OFF_HEND |=> reg_rdata_out == $past(st_ff.hend))
    else $error("Sync stop read back wrong.");
  AST_RD_SYNC: assert property (@(posedge mclk_in) disable iff (srst_in)
    reg_req_in.addr == VSC_OFF_SYNC |=> reg_rdata_out == 8'($past(st_ff.ctrl)))
    else $error("Sync control read back wrong.");
  AST_RD_STATUS: assert property (@(posedge mclk_in) disable iff (srst_in)
    reg_req_in.addr == VSC_OFF_STATUS |=> reg_rdata_out[VSC_STAT_STD_BIT] == $past(field_60hz_out)
    && reg_rdata_out[VSC_STAT_ERR_BIT] == $past(delay_range_err_out))
    else $error("Status read back wrong.");
endmodule // vsc_sync_ctrl
`default_nettype wire

// ---- test/tb_video_sync_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_video_sync_control;
  import vsc_pkg::*;
  logic mclk_in;
  logic srst_in;
  vsc_regreq_t reg_req_in;
  logic line_ref_in;
  logic field_start_in;
  logic detect_60hz_in;
  logic source_interlaced_in;
  logic [7:0] reg_rdata_out;
  logic hsync_out;
  logic field_60hz_out;
  logic odd_even_out;
  vsc_htc_t horiz_time_constant_out;
  logic horiz_loop_open_out;
  vsc_vnoise_t vert_noise_mode_out;
  logic delay_range_err_out;
  int errors;
  int checked;

  vsc_sync_ctrl vsc_sync_ctrl_inst (.mclk_in, .srst_in, .reg_req_in, .reg_rdata_out,
    .line_ref_in, .field_start_in, .detect_60hz_in, .source_interlaced_in, .hsync_out,
    .field_60hz_out, .odd_even_out, .horiz_time_constant_out, .horiz_loop_open_out,
    .vert_noise_mode_out, .delay_range_err_out);

  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  // ---------------------------------------------------------------------
  // Bus cycles and comparison
  // ---------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Write one register and let the registered outputs settle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_req_in <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge mclk_in);
    reg_req_in.wr <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_in);
    reg_req_in.addr <= a;
    repeat (2) @(posedge mclk_in);
    #1 check("rdata", reg_rdata_out, exp);
  endtask

  task automatic pulse_field();
    @(posedge mclk_in);
    field_start_in <= 1'b1;
    @(posedge mclk_in);
    field_start_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset();
    rdchk(VSC_OFF_HBEGIN, VSC_RST_HBEGIN);
    rdchk(VSC_OFF_HEND, VSC_RST_HEND);
    rdchk(VSC_OFF_SYNC, VSC_RST_SYNC);
    rdchk(8'h20, 8'h00);
    rdchk(VSC_OFF_STATUS, 8'h00);
    check("field", 8'(field_60hz_out), 8'h00);
    check("vnoise", 8'(vert_noise_mode_out), 8'h00);
    check("hsync", 8'(hsync_out), 8'h00);
    check("htc", 8'(horiz_time_constant_out), 8'h03);
    check("loop", 8'(horiz_loop_open_out), 8'h00);
  endtask

  task automatic t_ctrl();
    logic [7:0] d;
    logic [1:0] h;
    for (int i = 0; i < 16; i++) begin
      h = (i[3:2] == 2'b10) ? 2'b11 : i[3:2];
      d = {i[1:0] != 2'b01, 2'b00, h, i[1] ^ i[0], i[1:0]};
      if (i[1:0] == 2'b01) begin
        wr(VSC_OFF_SYNC, {d[7:2], 2'b00});
      end
      wr(VSC_OFF_SYNC, d);
      check("htc", 8'(horiz_time_constant_out), 8'(h));
      check("loop", 8'(horiz_loop_open_out), 8'(i[1] ^ i[0]));
      check("vnoise", 8'(vert_noise_mode_out), 8'(i[1:0]));
      rdchk(VSC_OFF_SYNC, d);
    end
  endtask

  task automatic t_field();
    detect_60hz_in <= 1'b1;
    wr(VSC_OFF_SYNC, 8'h98);
    check("field", 8'(field_60hz_out), 8'h01);
    rdchk(VSC_OFF_STATUS, 8'h01);
    wr(VSC_OFF_SYNC, 8'h18);
    check("field", 8'(field_60hz_out), 8'h00);
    wr(VSC_OFF_SYNC, 8'h58);
    detect_60hz_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 check("field", 8'(field_60hz_out), 8'h01);
  endtask

  task automatic t_toggle();
    logic v;
    source_interlaced_in <= 1'b0;
    wr(VSC_OFF_SYNC, 8'h18);
    v = 1'b0;
    pulse_field();
    check("oddeven", 8'(odd_even_out), 8'(v));
    wr(VSC_OFF_SYNC, 8'h38);
    pulse_field();
    check("oddeven", 8'(odd_even_out), 8'(!v));
    wr(VSC_OFF_SYNC, 8'h18);
    source_interlaced_in <= 1'b1;
    pulse_field();
    check("oddeven", 8'(odd_even_out), 8'(v));
  endtask

  task automatic t_range();
    wr(VSC_OFF_HEND, 8'h00);
    wr(VSC_OFF_HBEGIN, 8'h6C);
    check("err", 8'(delay_range_err_out), 8'h00);
    wr(VSC_OFF_HBEGIN, 8'h6D);
    check("err", 8'(delay_range_err_out), 8'h01);
    wr(VSC_OFF_HBEGIN, 8'h7F);
    check("err", 8'(delay_range_err_out), 8'h01);
    wr(VSC_OFF_HBEGIN, 8'h94);
    check("err", 8'(delay_range_err_out), 8'h00);
    wr(VSC_OFF_SYNC, 8'h58);
    check("err", 8'(delay_range_err_out), 8'h01);
    wr(VSC_OFF_HBEGIN, 8'h95);
    check("err", 8'(delay_range_err_out), 8'h00);
    wr(VSC_OFF_HEND, 8'h6C);
    check("err", 8'(delay_range_err_out), 8'h01);
  endtask

  // Sync window of four steps, from -2 to 2, must last 32 clocks.
  task automatic t_hsync();
    int n;
    int first;
    wr(VSC_OFF_SYNC, 8'h18);
    wr(VSC_OFF_HBEGIN, 8'hFE);
    wr(VSC_OFF_HEND, 8'h02);
    rdchk(VSC_OFF_HBEGIN, 8'hFE);
    n = 0;
    first = -1;
    @(posedge mclk_in);
    line_ref_in <= 1'b1;
    @(posedge mclk_in);
    line_ref_in <= 1'b0;
    for (int c = 0; c < 1000; c++) begin
      @(posedge mclk_in);
      #1 n += int'(hsync_out === 1'b1);
      if (hsync_out === 1'b1 && first < 0) begin
        first = c;
      end
    end
    check("hsync_len", 8'(n), 8'(4 * VSC_STEP_CLKS));
    check("hsync_step", 8'(first / VSC_STEP_CLKS), 8'(int'(VSC_LIMIT_50HZ) - 2));
    check("hsync_phase", 8'(first % VSC_STEP_CLKS), 8'h00);
  endtask

  task automatic end_of_test();
    if (errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    errors = 0;
    checked = 0;
    srst_in = 1'b1;
    reg_req_in = '0;
    line_ref_in = 1'b0;
    field_start_in = 1'b0;
    detect_60hz_in = 1'b0;
    source_interlaced_in = 1'b0;
    repeat (4) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_reset();
    t_ctrl();
    t_field();
    t_toggle();
    t_range();
    t_hsync();
    end_of_test();
  end
endmodule // tb_video_sync_control
`default_nettype wire
